// [inc/hdsrv_pkg.sv]
/*
  Package for the headphone offset servo controller: register offsets,
  field positions, reset values and timing counts.
  Assumes a 200 MHz system clock and a plain address/strobe register port.
*/
// Function
// - Enable bits 0/1 gate left/right servo.
// - Start-up trigger bits 4/5 measure then correct.
// - Start-up calibration takes about 25 ms.
// - Load trigger bits 2/3 copy stored offset.
// - Stored load takes about 2 ms.
// - Stored offsets 8-bit two's complement, right high.
// - Trigger bits read 1 while running.
// - Start-up done status in bits 1:0.
// - Stored load done status in bits 5:4.
// - Bits 9:8 OR both done fields.
// - Single trigger bits 12/13 one measure-adjust.
// - Each adjust moves correction one step at most.
// - Period field schedules 0.256 s times 2^n adjusts; 0 stops them.
// - Series trigger bits 8/9 run counted adjusts.
// - Series count field 11:5 requests value plus one.
// - Readback registers show present correction values.
// - Correction holds after calibration finishes.
`default_nettype none
package hdsrv_pkg;
  localparam int unsigned HDSRV_CLK_HZ = 200000000;
  localparam logic [7:0] HDSRV_ADR_TRIG = 8'h54;
  localparam logic [7:0] HDSRV_ADR_CFG = 8'h55;
  localparam logic [7:0] HDSRV_ADR_STORE = 8'h57;
  localparam logic [7:0] HDSRV_ADR_STAT = 8'h58;
  localparam logic [7:0] HDSRV_ADR_RRD = 8'h59;
  localparam logic [7:0] HDSRV_ADR_LRD = 8'h5A;
  localparam logic [7:0] HDSRV_ADR_IRQ_STAT = 8'h5B;
  localparam logic [7:0] HDSRV_ADR_IRQ_MASK = 8'h5C;
  // Trigger register field positions (left channel; right is one above).
  localparam int HDSRV_B_ENA = 0;
  localparam int HDSRV_B_LOAD = 2;
  localparam int HDSRV_B_START = 4;
  localparam int HDSRV_B_SERIES = 8;
  localparam int HDSRV_B_SINGLE = 12;
  // Configuration and status field positions.
  localparam int HDSRV_B_PERIOD = 0;
  localparam int HDSRV_B_COUNT = 5;
  localparam int HDSRV_B_ST_START = 0;
  localparam int HDSRV_B_ST_LOAD = 4;
  localparam int HDSRV_B_ST_ANY = 8;
  localparam logic [3:0] HDSRV_PERIOD_RST = 4'hA;
  localparam logic [6:0] HDSRV_COUNT_RST = 7'h2A;
  // Timing: figures in their own units and derived cycle counts.
  localparam int unsigned HDSRV_START_US = 25000;
  localparam int unsigned HDSRV_LOAD_US = 2000;
  localparam int unsigned HDSRV_TICK_MS = 256;
  localparam int unsigned HDSRV_START_CYC = HDSRV_START_US * (HDSRV_CLK_HZ / 1000000);
  localparam int unsigned HDSRV_LOAD_CYC = HDSRV_LOAD_US * (HDSRV_CLK_HZ / 1000000);
  localparam int unsigned HDSRV_TICK_CYC = HDSRV_TICK_MS * (HDSRV_CLK_HZ / 1000);
  localparam int unsigned HDSRV_MEAS_CYC = 64;
  // Interrupt status bit positions: per channel start-up done, load done, adjust done.
  localparam int HDSRV_IRQ_W = 6;
  typedef enum logic [4:0] {
    HDSRV_IDLE = 5'h01,
    HDSRV_MEAS = 5'h02,
    HDSRV_STEP = 5'h04,
    HDSRV_LOADW = 5'h08,
    HDSRV_DONE = 5'h10
  } hdsrv_state_e;
endpackage : hdsrv_pkg
`default_nettype wire

// [hdl/hdsrv_chan.sv]
/*
  One servo channel: sequences start-up, stored load, single and series
  adjusts and holds the correction value that drives the analogue DAC.
  Assumes the comparator sign input is settled whenever a measurement ends.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsrv_chan
  import hdsrv_pkg::*;
#(
  parameter int unsigned START_CYC = HDSRV_START_CYC,
  parameter int unsigned LOAD_CYC = HDSRV_LOAD_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic load_i,
  input wire logic single_i,
  input wire logic series_i,
  input wire logic [6:0] count_i,
  input wire logic [7:0] stored_i,
  input wire logic offset_high_i,
  output logic [7:0] correction_o,
  output logic [3:0] busy_o,
  output logic start_done_o,
  output logic load_done_o,
  output logic adjust_done_o
);
  // Saturating step, so the correction never wraps across the range end.
  function automatic logic [7:0] hdsrv_step(input logic [7:0] v, input logic down);
    if (down)
      return (v == 8'h80) ? v : v - 8'h01;
    else
      return (v == 8'h7F) ? v : v + 8'h01;
  endfunction : hdsrv_step

  hdsrv_state_e state_q, state_d;
  logic [31:0] timer_q, timer_d;
  logic [7:0] left_q, left_d;
  logic [3:0] busy_q, busy_d;
  logic [7:0] corr_q, corr_d;
  logic sdone_q, sdone_d;
  logic ldone_q, ldone_d;
  logic [31:0] start_meas;
  logic go;

  // Start-up spends its time in 128 measure-step passes of equal length.
  assign start_meas = START_CYC / 128;
  assign go = enable_i & (start_i | load_i | single_i | series_i);

  // Sequencer; a trigger arriving while busy is ignored.
  always_comb
  begin
    state_d = state_q;
    timer_d = timer_q;
    left_d = left_q;
    busy_d = busy_q;
    corr_d = corr_q;
    sdone_d = sdone_q;
    ldone_d = ldone_q;
    adjust_done_o = 1'b0;
    case (state_q)
      HDSRV_IDLE:
      begin
        if (go)
        begin
          // Only the operation that actually runs may show busy: load, then start, series, single.
          busy_d = load_i ? 4'h1 : (start_i ? 4'h2 : (series_i ? 4'h4 : 4'h8));
          if (load_i)
          begin
            ldone_d = 1'b0;
            timer_d = LOAD_CYC - 1;
            state_d = HDSRV_LOADW;
          end
          else
          begin
            if (start_i)
              sdone_d = 1'b0;
            left_d = start_i ? 8'd127 : (series_i ? {1'b0, count_i} : 8'd0);
            timer_d = start_i ? start_meas - 1 : HDSRV_MEAS_CYC - 1;
            state_d = HDSRV_MEAS;
          end
        end
      end
      HDSRV_MEAS:
      begin
        if (!enable_i)
          state_d = HDSRV_DONE;
        else if (timer_q == 32'd0)
          state_d = HDSRV_STEP;
        else
          timer_d = timer_q - 32'd1;
      end
      HDSRV_STEP:
      begin
        corr_d = hdsrv_step(corr_q, offset_high_i);
        if (left_q == 8'd0)
          state_d = HDSRV_DONE;
        else
        begin
          left_d = left_q - 8'd1;
          timer_d = busy_q[1] ? start_meas - 1 : HDSRV_MEAS_CYC - 1;
          state_d = HDSRV_MEAS;
        end
      end
      HDSRV_LOADW:
      begin
        if (!enable_i)
          state_d = HDSRV_DONE;
        else if (timer_q == 32'd0)
        begin
          corr_d = stored_i;
          state_d = HDSRV_DONE;
        end
        else
          timer_d = timer_q - 32'd1;
      end
      HDSRV_DONE:
      begin
        sdone_d = sdone_q | (busy_q[1] & enable_i);
        ldone_d = ldone_q | (busy_q[0] & enable_i);
        adjust_done_o = busy_q[3] | busy_q[2];
        busy_d = 4'h0;
        state_d = HDSRV_IDLE;
      end
      default:
        state_d = HDSRV_IDLE;
    endcase
  end

  // State registers; the correction is kept between operations.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= HDSRV_IDLE;
      timer_q <= 32'd0;
      left_q <= 8'h00;
      busy_q <= 4'h0;
      corr_q <= 8'h00;
      sdone_q <= 1'b0;
      ldone_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      timer_q <= timer_d;
      left_q <= left_d;
      busy_q <= busy_d;
      corr_q <= corr_d;
      sdone_q <= sdone_d;
      ldone_q <= ldone_d;
    end
  end

  assign correction_o = corr_q;
  assign busy_o = busy_q;
  assign start_done_o = sdone_q;
  assign load_done_o = ldone_q;
endmodule : hdsrv_chan
`default_nettype wire

// [hdl/hdsrv_top.sv]
/*
  Headphone offset servo controller: register file, periodic adjust timer,
  interrupt logic and the two channel sequencers.
  Assumes a single 200 MHz clock and a master that never overlaps strobes.
*/
// Added by the designer: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module hdsrv_top
  import hdsrv_pkg::*;
#(
  parameter int unsigned START_CYC = HDSRV_START_CYC,
  parameter int unsigned LOAD_CYC = HDSRV_LOAD_CYC,
  parameter int unsigned TICK_CYC = HDSRV_TICK_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  input wire logic left_offset_high_i,
  input wire logic right_offset_high_i,
  output logic [7:0] left_correction_o,
  output logic [7:0] right_correction_o,
  output logic irq_o
);
  logic [1:0] ena_q;
  logic [3:0] period_q;
  logic [6:0] count_q;
  logic [15:0] store_q;
  logic [15:0] rdata_q;
  logic [HDSRV_IRQ_W-1:0] irq_stat_q, irq_mask_q;
  logic [31:0] tick_q;
  logic [14:0] ticks_q;
  logic [1:0] periodic;
  logic [3:0] busy [2];
  logic [1:0] sdone, ldone, adone;
  logic [7:0] corr [2];
  logic [1:0] hi;
  logic wr_trig, wr_cfg, wr_store, wr_mask, rd_irq;
  logic tick_wrap, period_hit;
  logic [15:0] trig_rd, stat_rd, rd_mux;
  logic [1:0] ena_eff;
  logic [14:0] period_len;

  // Address decode.
  assign wr_trig = wr_i & (addr_i == HDSRV_ADR_TRIG);
  assign wr_cfg = wr_i & (addr_i == HDSRV_ADR_CFG);
  assign wr_store = wr_i & (addr_i == HDSRV_ADR_STORE);
  assign wr_mask = wr_i & (addr_i == HDSRV_ADR_IRQ_MASK);
  assign rd_irq = rd_i & (addr_i == HDSRV_ADR_IRQ_STAT);
  assign hi = {right_offset_high_i, left_offset_high_i};
  // A trigger written together with its enable bit sees the new enable, so one write can enable and start.
  assign ena_eff = wr_trig ? wdata_i[HDSRV_B_ENA +: 2] : ena_q;

  // Periodic scheduler: base tick of 0.256 s, period is 2^n ticks; a period field of 0 schedules none.
  assign tick_wrap = (tick_q == TICK_CYC - 1);
  assign period_len = 15'(1) << period_q;
  assign period_hit = tick_wrap & (period_q != 4'h0) & (ticks_q >= period_len - 15'd1);
  assign periodic = {2{period_hit}};

  // Two channel sequencers, left at index 0.
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    hdsrv_chan #(
      .START_CYC(START_CYC),
      .LOAD_CYC(LOAD_CYC)
    ) u_chan (
      .sys_clk_i(sys_clk_i),
      .reset_n_i(reset_n_i),
      .enable_i(ena_eff[c]),
      .start_i(wr_trig & wdata_i[HDSRV_B_START + c]),
      .load_i(wr_trig & wdata_i[HDSRV_B_LOAD + c]),
      .single_i((wr_trig & wdata_i[HDSRV_B_SINGLE + c]) | periodic[c]),
      .series_i(wr_trig & wdata_i[HDSRV_B_SERIES + c]),
      .count_i(count_q),
      .stored_i(store_q[8*c +: 8]),
      .offset_high_i(hi[c]),
      .correction_o(corr[c]),
      .busy_o(busy[c]),
      .start_done_o(sdone[c]),
      .load_done_o(ldone[c]),
      .adjust_done_o(adone[c])
    );
  end

  // Read views of the trigger and status registers.
  assign trig_rd = {2'b00, busy[1][3], busy[0][3], 2'b00, busy[1][2], busy[0][2],
                    2'b00, busy[1][1], busy[0][1], busy[1][0], busy[0][0], ena_q};
  assign stat_rd = {6'h00, sdone | ldone, 2'b00, ldone, 2'b00, sdone};

  // Read multiplexer; unmapped addresses read zero.
  always_comb
  begin
    case (addr_i)
      HDSRV_ADR_TRIG: rd_mux = trig_rd;
      HDSRV_ADR_CFG: rd_mux = {4'h0, count_q, 1'b0, period_q};
      HDSRV_ADR_STORE: rd_mux = store_q;
      HDSRV_ADR_STAT: rd_mux = stat_rd;
      HDSRV_ADR_RRD: rd_mux = {8'h00, corr[1]};
      HDSRV_ADR_LRD: rd_mux = {8'h00, corr[0]};
      HDSRV_ADR_IRQ_STAT: rd_mux = {10'h000, irq_stat_q};
      HDSRV_ADR_IRQ_MASK: rd_mux = {10'h000, irq_mask_q};
      default: rd_mux = 16'h0000;
    endcase
  end

  // Registers written by software.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ena_q <= 2'b00;
      period_q <= HDSRV_PERIOD_RST;
      count_q <= HDSRV_COUNT_RST;
      store_q <= 16'h0000;
      irq_mask_q <= '0;
    end
    else
    begin
      if (wr_trig)
        ena_q <= wdata_i[HDSRV_B_ENA +: 2];
      if (wr_cfg)
      begin
        period_q <= wdata_i[HDSRV_B_PERIOD +: 4];
        count_q <= wdata_i[HDSRV_B_COUNT +: 7];
      end
      if (wr_store)
        store_q <= wdata_i;
      if (wr_mask)
        irq_mask_q <= wdata_i[HDSRV_IRQ_W-1:0];
    end
  end

  // Periodic timer restarts when the period field is rewritten.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      tick_q <= 32'd0;
      ticks_q <= 15'd0;
    end
    else if (wr_cfg || period_q == 4'h0)
    begin
      tick_q <= 32'd0;
      ticks_q <= 15'd0;
    end
    else if (tick_wrap)
    begin
      tick_q <= 32'd0;
      ticks_q <= period_hit ? 15'd0 : ticks_q + 15'd1;
    end
    else
      tick_q <= tick_q + 32'd1;
  end

  // Sticky interrupt status; a new event wins over the clear-on-read.
  logic [1:0] sdone_q, ldone_q;
  logic [HDSRV_IRQ_W-1:0] ev;
  assign ev = {adone, ldone & ~ldone_q, sdone & ~sdone_q};
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      irq_stat_q <= '0;
      sdone_q <= 2'b00;
      ldone_q <= 2'b00;
      rdata_q <= 16'h0000;
    end
    else
    begin
      sdone_q <= sdone;
      ldone_q <= ldone;
      irq_stat_q <= (rd_irq ? '0 : irq_stat_q) | ev;
      rdata_q <= rd_i ? rd_mux : 16'h0000;
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);
  assign rdata_o = rdata_q;
  assign left_correction_o = corr[0];
  assign right_correction_o = corr[1];
endmodule : hdsrv_top
`default_nettype wire

// [testbench/hdsrv_top_sva.sv]
/*
  Checker for the servo controller: read path, enable gating and interrupt masking.
  Assumes it is bound to hdsrv_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsrv_top_sva
  import hdsrv_pkg::*;
#(
  parameter int unsigned START_CYC = 1,
  parameter int unsigned LOAD_CYC = 1,
  parameter int unsigned TICK_CYC = 1
)
(
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic left_offset_high_i,
  input wire logic right_offset_high_i,
  input wire logic [7:0] left_correction_o,
  input wire logic [7:0] right_correction_o,
  input wire logic irq_o
);
  logic [1:0] en_q;
  logic [5:0] mask_q;
  logic [15:0] store_q;
  logic [10:0] cfg_q;
  // Read decodes, named so that the sampled-value functions see plain signals.
  wire rd_trig = rd_i && addr_i == HDSRV_ADR_TRIG;
  wire rd_cfg = rd_i && addr_i == HDSRV_ADR_CFG;
  wire rd_store = rd_i && addr_i == HDSRV_ADR_STORE;
  wire rd_stat = rd_i && addr_i == HDSRV_ADR_STAT;
  wire rd_left = rd_i && addr_i == HDSRV_ADR_LRD;
  wire rd_bad = rd_i && (addr_i < 8'h54 || addr_i > 8'h5C || addr_i == 8'h56);
  // Shadow copies of the writable fields, so that reads of those fields can be predicted.
  always_ff @(posedge sys_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      en_q <= 2'h0;
      mask_q <= 6'h00;
      store_q <= 16'h0000;
      cfg_q <= {HDSRV_COUNT_RST, HDSRV_PERIOD_RST};
    end
    else if (wr_i)
    begin
      if (addr_i == HDSRV_ADR_TRIG) en_q <= wdata_i[1:0];
      if (addr_i == HDSRV_ADR_IRQ_MASK) mask_q <= wdata_i[5:0];
      if (addr_i == HDSRV_ADR_STORE) store_q <= wdata_i;
      if (addr_i == HDSRV_ADR_CFG) cfg_q <= {wdata_i[11:5], wdata_i[3:0]};
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_rd_idle: assert property (!$past(rd_i) |-> rdata_o == 16'h0000)
    else $error("Read data not zero outside the read answer cycle.");
  a_rd_unmapped: assert property ($past(rd_bad) |-> rdata_o == 16'h0000)
    else $error("Unmapped address returned nonzero data.");
  a_trig_enables: assert property ($past(rd_trig) |-> rdata_o[1:0] == $past(en_q))
    else $error("Enable bits read back wrong.");
  // An abort by disabling can leave busy up for two more cycles, so the enable must have been low for three.
  a_trig_gated: assert property ($past(rd_trig) && !$past(en_q[0]) && !$past(en_q[0], 2) && !$past(en_q[0], 3)
    |-> {rdata_o[12], rdata_o[8], rdata_o[4], rdata_o[2]} == 4'h0)
    else $error("Trigger shows busy on a disabled channel.");
  a_dis_hold: assert property (!en_q[0] && !$past(en_q[0]) |-> $stable(left_correction_o))
    else $error("Correction moved while the channel was disabled.");
  a_stat_or: assert property ($past(rd_stat) |-> rdata_o[9:8] == (rdata_o[1:0] | rdata_o[5:4]))
    else $error("Combined done field differs from its parts.");
  a_store_rd: assert property ($past(rd_store) |-> rdata_o == $past(store_q))
    else $error("Stored offsets read back wrong.");
  a_cfg_rd: assert property ($past(rd_cfg) |-> {rdata_o[11:5], rdata_o[3:0]} == $past(cfg_q))
    else $error("Period or count field read back wrong.");
  a_left_rd: assert property ($past(rd_left) |-> rdata_o == {8'h00, $past(left_correction_o)})
    else $error("Left readback differs from the applied correction.");
  a_irq_masked: assert property (mask_q == 6'h00 && $past(mask_q) == 6'h00 |-> !irq_o)
    else $error("Interrupt raised with every source masked.");
endmodule : hdsrv_top_sva
bind hdsrv_top hdsrv_top_sva #(.START_CYC(START_CYC), .LOAD_CYC(LOAD_CYC), .TICK_CYC(TICK_CYC)) hdsrv_top_sva_i (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .left_offset_high_i(left_offset_high_i), .right_offset_high_i(right_offset_high_i),
  .left_correction_o(left_correction_o), .right_correction_o(right_correction_o), .irq_o(irq_o));
`default_nettype wire

// [testbench/hdsrv_analog_model.sv]
/*
  Model of the analogue offset measurement and correction circuit.
  Assumes corrections are two's complement steps of 0.25 mV.
*/
`timescale 1ns/1ps
`default_nettype none
module hdsrv_analog_model
#(
  parameter logic signed [7:0] LEFT_OFFS = 8'sh05,
  parameter logic signed [7:0] RIGHT_OFFS = 8'shF9
)
(
  input wire logic [7:0] left_correction_i,
  input wire logic [7:0] right_correction_i,
  output logic left_offset_high_o,
  output logic right_offset_high_o
);
  // Residual output DC is the raw offset plus the applied correction; the sign feeds the comparator.
  wire signed [8:0] left_dc = LEFT_OFFS + $signed(left_correction_i);
  wire signed [8:0] right_dc = RIGHT_OFFS + $signed(right_correction_i);
  assign left_offset_high_o = left_dc > 0;
  assign right_offset_high_o = right_dc > 0;
endmodule : hdsrv_analog_model
`default_nettype wire

// [testbench/testbench.sv]
/*
  Testbench for the servo controller: register tasks and directed mode sequences.
  Assumes shortened start-up, load and tick counts and the analogue model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import hdsrv_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic [15:0] rdata_o;
  logic [7:0] lc;
  logic [7:0] rc;
  logic irq_o;
  logic lh;
  logic rh;
  logic [15:0] rv;
  int errors = 0;
  int total_checks = 0;
  logic [7:0] ra [7] = '{8'h54, 8'h55, 8'h56, 8'h57, 8'h58, 8'h59, 8'h5A};
  logic [15:0] re [7] = '{16'h0000, 16'h054A, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  // A 5 ns clock.
  always #2.5 sys_clk_i = ~sys_clk_i;
  hdsrv_top #(.START_CYC(1280), .LOAD_CYC(100), .TICK_CYC(50)) hdsrv_top_i (.sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .left_offset_high_i(lh), .right_offset_high_i(rh), .left_correction_o(lc), .right_correction_o(rc),
    .irq_o(irq_o));
  hdsrv_analog_model hdsrv_analog_model_i (.left_correction_i(lc), .right_correction_i(rc),
    .left_offset_high_o(lh), .right_offset_high_o(rh));
  task conclude;
    if (errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude
  task check(input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check
  // The servo dithers by one step around zero residual, so either neighbour is right.
  task near(input logic [15:0] g, input logic [15:0] a, input logic [15:0] b);
    total_checks++;
    if (g !== a && g !== b)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, a);
    end
  endtask : near
  task idle(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : idle
  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample just past that edge.
  task rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd
  task rchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    rd(a, d);
    check(d, e);
  endtask : rchk
  // Main sequence; the outputs count as muted and shorted while start-up and load run.
  initial
  begin
    idle(12);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 7; i++) rchk(ra[i], re[i]);
    wr(8'h54, 16'h0010);
    rchk(8'h54, 16'h0000);
    wr(8'h55, 16'h0060);
    wr(8'h5C, 16'h003F);
    rchk(8'h55, 16'h0060);
    wr(8'h54, 16'h0033);
    rchk(8'h54, 16'h0033);
    idle(1580);
    rchk(8'h54, 16'h0003);
    rchk(8'h58, 16'h0303);
    check({15'h0000, irq_o}, 16'h0001);
    rchk(8'h5B, 16'h0003);
    check({15'h0000, irq_o}, 16'h0000);
    rd(8'h5A, rv);
    near(rv, 16'h00FB, 16'h00FC);
    rd(8'h59, rv);
    near(rv, 16'h0007, 16'h0008);
    wr(8'h5C, 16'h0000);
    wr(8'h57, 16'h807F);
    rchk(8'h57, 16'h807F);
    wr(8'h54, 16'h000F);
    rchk(8'h54, 16'h000F);
    idle(120);
    check({lc, rc}, 16'h7F80);
    rchk(8'h58, 16'h0333);
    wr(8'h54, 16'h1003);
    idle(84);
    rchk(8'h5A, 16'h007E);
    rchk(8'h59, 16'h0080);
    wr(8'h54, 16'h0203);
    rchk(8'h54, 16'h0203);
    idle(300);
    rchk(8'h59, 16'h0084);
    rchk(8'h5B, 16'h003C);
    check({15'h0000, irq_o}, 16'h0000);
    wr(8'h55, 16'h0061);
    idle(180);
    wr(8'h55, 16'h0060);
    idle(100);
    check({lc, rc}, 16'h7D85);
    // Load beats start on the left, the right starts; then disabling aborts the right start-up.
    wr(8'h54, 16'h0037);
    rchk(8'h54, 16'h0027);
    idle(110);
    rchk(8'h5A, 16'h007F);
    wr(8'h54, 16'h0000);
    idle(2);
    rchk(8'h54, 16'h0000);
    rchk(8'h58, 16'h0331);
    conclude();
  end
  // Watchdog: the sequence needs under 3500 cycles.
  initial
  begin
    idle(20000);
    errors++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
